// [tlr_pkg.sv]
// Constants, types and register map of the typed latch register block
package tlr_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_START  = 8'h04;
    localparam logic [7:0] OFF_INIT_F = 8'h08;
    localparam logic [7:0] OFF_INIT_S = 8'h0c;
    localparam logic [7:0] OFF_FVAL   = 8'h10;
    localparam logic [7:0] OFF_SVAL   = 8'h14;
    localparam logic [7:0] OFF_STAT   = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_MODE_F_LSB = 0;
    localparam int CTRL_MODE_S_LSB = 4;
    localparam int CTRL_PERSIST    = 8;
    localparam int CTRL_LOAD_INIT  = 9;
    localparam int START_GO        = 0;
    localparam int STAT_RUNNING    = 0;
    localparam int STAT_RESTORED   = 1;
    localparam int STAT_LATCH      = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_INIT_F = 32'h0000_0000;
    localparam logic [31:0] RST_INIT_S = 32'h0000_0000;

    // ************************************************************
    // Enumerations
    // ************************************************************
    typedef enum logic [2:0] {
        TLR_MODE_HIGH = 3'h0,
        TLR_MODE_LOW  = 3'h1,
        TLR_MODE_RISE = 3'h2,
        TLR_MODE_FALL = 3'h3,
        TLR_MODE_BOTH = 3'h4
    } tlr_mode_e;

    typedef enum logic [1:0] {
        TLR_KIND_BOOL  = 2'h0,
        TLR_KIND_WORD  = 2'h1,
        TLR_KIND_LONG  = 2'h2,
        TLR_KIND_FLOAT = 2'h3
    } tlr_kind_e;

    typedef enum logic [1:0] {
        TLR_ST_IDLE = 2'b00,
        TLR_ST_LOAD = 2'b01,
        TLR_ST_RUN  = 2'b11
    } tlr_state_e;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [31:0] float_bits;
        logic [31:0] signed_val;
    } tlr_pair_s;

endpackage

// [tlr_capture.sv]
// Capture decision for one register variant, evaluated once per scan
`timescale 1ns/1ps
module tlr_capture (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                scan,
    input  wire logic                run,
    input  wire tlr_pkg::tlr_mode_e  mode,
    input  wire logic                latch,
    output logic                     capture
);

    logic prev_q;
    logic prev_d;

    // Previous scan's latch sample; cleared so a high latch at the
    // first scan counts as a rising edge
    always_comb begin
        prev_d = prev_q;
        if (!run) begin
            prev_d = 1'b0;
        end else if (scan) begin
            prev_d = latch;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    always_comb begin
        capture = 1'b0;
        if (run && scan) begin
            case (mode)
                tlr_pkg::TLR_MODE_HIGH: capture = latch;
                tlr_pkg::TLR_MODE_LOW:  capture = !latch;
                tlr_pkg::TLR_MODE_RISE: begin
                    capture = latch && !prev_q;
                end
                tlr_pkg::TLR_MODE_FALL: begin
                    capture = !latch && prev_q;
                end
                tlr_pkg::TLR_MODE_BOTH: begin
                    capture = latch != prev_q;
                end
                default: capture = 1'b0;
            endcase
        end
    end

endmodule

// [tlr_convert.sv]
// Casts the data input to both register types
`timescale 1ns/1ps
module tlr_convert (
    input  wire logic [31:0]        data_in,
    input  wire tlr_pkg::tlr_kind_e data_kind,
    output tlr_pkg::tlr_pair_s      value
);

    // Signed integer to single precision; low bits beyond 24 are
    // truncated, every value up to 2**24 is exact
    function automatic logic [31:0] int_to_float(input logic [31:0] v);
        logic        sgn;
        logic [31:0] mag;
        logic [31:0] norm;
        logic [7:0]  expo;
        int          top;
        sgn  = v[31];
        mag  = sgn ? (~v + 32'h0000_0001) : v;
        top  = 0;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                top = i;
            end
        end
        norm = mag << (31 - top);
        expo = 8'(127 + top);
        if (mag == 32'h0000_0000) begin
            int_to_float = 32'h0000_0000;
        end else begin
            int_to_float = {sgn, expo, norm[30:8]};
        end
    endfunction

    // Single precision to signed integer, fraction dropped; values
    // beyond the 32-bit range saturate
    function automatic logic [31:0] float_to_int(input logic [31:0] f);
        logic [31:0] mant;
        logic [31:0] mag;
        int          e;
        mant = {8'h00, 1'b1, f[22:0]};
        e    = int'(f[30:23]) - 127;
        mag  = 32'h0000_0000;
        if (e < 0) begin
            mag = 32'h0000_0000;
        end else if (e >= 31) begin
            mag = f[31] ? 32'h8000_0000 : 32'h7fff_ffff;
        end else if (e >= 23) begin
            mag = mant << (e - 23);
        end else begin
            mag = mant >> (23 - e);
        end
        float_to_int = f[31] ? (~mag + 32'h0000_0001) : mag;
    endfunction

    always_comb begin
        value = '0;
        case (data_kind)
            tlr_pkg::TLR_KIND_BOOL: begin
                value.signed_val = {31'h0000_0000, data_in[0]};
                value.float_bits = int_to_float(value.signed_val);
            end
            tlr_pkg::TLR_KIND_WORD: begin
                value.signed_val = {16'h0000, data_in[15:0]};
                value.float_bits = int_to_float(value.signed_val);
            end
            tlr_pkg::TLR_KIND_LONG: begin
                value.signed_val = data_in;
                value.float_bits = int_to_float(data_in);
            end
            default: begin
                value.float_bits = data_in;
                value.signed_val = float_to_int(data_in);
            end
        endcase
    end

endmodule

// [tlr_top.sv]
// Typed latch register: float and signed variants behind an APB slave
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tlr_top (
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Upstream function blocks
    input  wire logic               scan_strobe,
    input  wire logic [31:0]        data_in,
    input  wire tlr_pkg::tlr_kind_e data_kind,
    input  wire logic               latch_in,
    input  wire logic               latch_connected,
    input  wire logic               new_project,
    // Non-volatile store
    input  wire logic               nv_saved_valid,
    input  wire tlr_pkg::tlr_pair_s nv_saved,
    output logic                    nv_write,
    output tlr_pkg::tlr_pair_s      nv_write_data,
    // Register outputs
    output logic [31:0]             float_value_out,
    output logic [31:0]             signed_value_out
);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    tlr_pkg::tlr_mode_e mode_f_q;
    tlr_pkg::tlr_mode_e mode_f_d;
    tlr_pkg::tlr_mode_e mode_s_q;
    tlr_pkg::tlr_mode_e mode_s_d;
    logic               persist_q;
    logic               persist_d;
    logic               load_init_q;
    logic               load_init_d;
    logic [31:0]        init_f_q;
    logic [31:0]        init_f_d;
    logic [31:0]        init_s_q;
    logic [31:0]        init_s_d;
    logic               go;
    logic               wr_acc;

    assign wr_acc = psel && penable && pwrite;
    assign go     = wr_acc && (paddr == tlr_pkg::OFF_START)
                    && pwdata[tlr_pkg::START_GO];

    // Codes outside the five modes are ignored on write, so the field
    // always names exactly one mode
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = m <= 3'h4;
    endfunction

    always_comb begin
        mode_f_d    = mode_f_q;
        mode_s_d    = mode_s_q;
        persist_d   = persist_q;
        load_init_d = load_init_q;
        init_f_d    = init_f_q;
        init_s_d    = init_s_q;
        if (wr_acc) begin
            if (paddr == tlr_pkg::OFF_CTRL) begin
                if (mode_ok(pwdata[tlr_pkg::CTRL_MODE_F_LSB +: 3])) begin
                    mode_f_d = tlr_pkg::tlr_mode_e'(
                        pwdata[tlr_pkg::CTRL_MODE_F_LSB +: 3]);
                end
                if (mode_ok(pwdata[tlr_pkg::CTRL_MODE_S_LSB +: 3])) begin
                    mode_s_d = tlr_pkg::tlr_mode_e'(
                        pwdata[tlr_pkg::CTRL_MODE_S_LSB +: 3]);
                end
                persist_d   = pwdata[tlr_pkg::CTRL_PERSIST];
                load_init_d = pwdata[tlr_pkg::CTRL_LOAD_INIT];
            end else if (paddr == tlr_pkg::OFF_INIT_F) begin
                init_f_d = pwdata;
            end else if (paddr == tlr_pkg::OFF_INIT_S) begin
                init_s_d = pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_f_q    <= tlr_pkg::tlr_mode_e'(tlr_pkg::RST_CTRL[2:0]);
            mode_s_q    <= tlr_pkg::tlr_mode_e'(tlr_pkg::RST_CTRL[6:4]);
            persist_q   <= tlr_pkg::RST_CTRL[tlr_pkg::CTRL_PERSIST];
            load_init_q <= tlr_pkg::RST_CTRL[tlr_pkg::CTRL_LOAD_INIT];
            init_f_q    <= tlr_pkg::RST_INIT_F;
            init_s_q    <= tlr_pkg::RST_INIT_S;
        end else begin
            mode_f_q    <= mode_f_d;
            mode_s_q    <= mode_s_d;
            persist_q   <= persist_d;
            load_init_q <= load_init_d;
            init_f_q    <= init_f_d;
            init_s_q    <= init_s_d;
        end
    end

    // ************************************************************
    // Start-up sequence and value registers
    // ************************************************************
    tlr_pkg::tlr_state_e state_q;
    tlr_pkg::tlr_state_e state_d;
    logic [31:0]         fval_q;
    logic [31:0]         fval_d;
    logic [31:0]         sval_q;
    logic [31:0]         sval_d;
    logic                restored_q;
    logic                restored_d;
    logic                nv_write_q;
    logic                nv_write_d;
    logic                latch;
    logic                run;
    logic                cap_f;
    logic                cap_s;
    tlr_pkg::tlr_pair_s  conv;

    assign latch = latch_connected && latch_in;
    assign run   = state_q == tlr_pkg::TLR_ST_RUN;

    tlr_capture u_cap_float (
        .pclk    (pclk),
        .presetn (presetn),
        .scan    (scan_strobe),
        .run     (run),
        .mode    (mode_f_q),
        .latch   (latch),
        .capture (cap_f)
    );

    tlr_capture u_cap_signed (
        .pclk    (pclk),
        .presetn (presetn),
        .scan    (scan_strobe),
        .run     (run),
        .mode    (mode_s_q),
        .latch   (latch),
        .capture (cap_s)
    );

    tlr_convert u_convert (
        .data_in   (data_in),
        .data_kind (data_kind),
        .value     (conv)
    );

    always_comb begin
        state_d    = state_q;
        fval_d     = fval_q;
        sval_d     = sval_q;
        restored_d = restored_q;
        nv_write_d = 1'b0;
        case (state_q)
            tlr_pkg::TLR_ST_IDLE: begin
                if (go) begin
                    state_d = tlr_pkg::TLR_ST_LOAD;
                end
            end
            tlr_pkg::TLR_ST_LOAD: begin
                // Saved copy wins after power return; after a fresh
                // download the load-initial choice decides
                if (persist_q && nv_saved_valid
                    && !(new_project && load_init_q)) begin
                    fval_d     = nv_saved.float_bits;
                    sval_d     = nv_saved.signed_val;
                    restored_d = 1'b1;
                end else begin
                    fval_d     = init_f_q;
                    sval_d     = init_s_q;
                    restored_d = 1'b0;
                end
                state_d = tlr_pkg::TLR_ST_RUN;
            end
            tlr_pkg::TLR_ST_RUN: begin
                if (go) begin
                    state_d = tlr_pkg::TLR_ST_LOAD;
                end else begin
                    // Without a capture both values stay put
                    if (cap_f) begin
                        fval_d = conv.float_bits;
                    end
                    if (cap_s) begin
                        sval_d = conv.signed_val;
                    end
                    nv_write_d = persist_q && (cap_f || cap_s);
                end
            end
            default: state_d = tlr_pkg::TLR_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= tlr_pkg::TLR_ST_IDLE;
            fval_q     <= tlr_pkg::RST_INIT_F;
            sval_q     <= tlr_pkg::RST_INIT_S;
            restored_q <= 1'b0;
            nv_write_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            fval_q     <= fval_d;
            sval_q     <= sval_d;
            restored_q <= restored_d;
            nv_write_q <= nv_write_d;
        end
    end

    assign float_value_out  = fval_q;
    assign signed_value_out = sval_q;
    assign nv_write         = nv_write_q;
    assign nv_write_data    = '{float_bits: fval_q, signed_val: sval_q};

    // ************************************************************
    // APB read path
    // ************************************************************
    // Read data and error are caught in the setup cycle so the
    // access phase completes at once with registered outputs
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;
    logic        setup;

    assign setup = psel && !penable;

    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d   = 1'b0;
            if (paddr == tlr_pkg::OFF_CTRL) begin
                rdata_d[tlr_pkg::CTRL_MODE_F_LSB +: 3] = mode_f_q;
                rdata_d[tlr_pkg::CTRL_MODE_S_LSB +: 3] = mode_s_q;
                rdata_d[tlr_pkg::CTRL_PERSIST]         = persist_q;
                rdata_d[tlr_pkg::CTRL_LOAD_INIT]       = load_init_q;
            end else if (paddr == tlr_pkg::OFF_START) begin
                rdata_d = 32'h0000_0000;
            end else if (paddr == tlr_pkg::OFF_INIT_F) begin
                rdata_d = init_f_q;
            end else if (paddr == tlr_pkg::OFF_INIT_S) begin
                rdata_d = init_s_q;
            end else if (paddr == tlr_pkg::OFF_FVAL) begin
                rdata_d = fval_q;
                err_d   = pwrite;
            end else if (paddr == tlr_pkg::OFF_SVAL) begin
                rdata_d = sval_q;
                err_d   = pwrite;
            end else if (paddr == tlr_pkg::OFF_STAT) begin
                rdata_d[tlr_pkg::STAT_RUNNING]  = run;
                rdata_d[tlr_pkg::STAT_RESTORED] = restored_q;
                rdata_d[tlr_pkg::STAT_LATCH]    = latch;
                err_d   = pwrite;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;

endmodule

// [tlr_top_asserts.sv]
// Port-level checks of the typed latch register
`timescale 1ns/1ps
module tlr_top_asserts (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               scan_strobe,
    input wire logic [31:0]        data_in,
    input wire tlr_pkg::tlr_kind_e data_kind,
    input wire logic               latch_in,
    input wire logic               latch_connected,
    input wire logic               nv_write,
    input wire tlr_pkg::tlr_pair_s nv_write_data,
    input wire logic [31:0]        float_value_out,
    input wire logic [31:0]        signed_value_out
);
    // ********************
    // Shadow of configuration and run state
    // ********************
    logic        wr, st_wr, eff, cf, cs, sc;
    logic        st1_q, st1_d, run_q, run_d, prev_q, prev_d, per_q, per_d;
    logic [2:0]  mf_q, mf_d, ms_q, ms_d;
    logic [31:0] if_q, if_d, is_q, is_d;

    function automatic logic capt(input logic [2:0] m, input logic l, p);
        case (m)
            3'h0: capt = l;
            3'h1: capt = !l;
            3'h2: capt = l && !p;
            3'h3: capt = !l && p;
            default: capt = l != p;
        endcase
    endfunction

    assign wr    = psel && penable && pwrite;
    assign st_wr = wr && paddr == tlr_pkg::OFF_START && pwdata[0];
    assign eff   = latch_in && latch_connected;
    assign cf    = capt(mf_q, eff, prev_q);
    assign cs    = capt(ms_q, eff, prev_q);
    // A scan in the cycle of a start write is dropped by the design
    assign sc    = run_q && scan_strobe && !st_wr;

    always_comb begin
        st1_d  = st_wr;
        run_d  = st1_q || (run_q && !st_wr);
        prev_d = run_q ? (scan_strobe ? eff : prev_q) : 1'b0;
        per_d  = per_q;
        mf_d   = mf_q;
        ms_d   = ms_q;
        if_d   = if_q;
        is_d   = is_q;
        if (wr && paddr == tlr_pkg::OFF_CTRL) begin
            per_d = pwdata[8];
            // Codes above both-edges leave the field as it was
            if (pwdata[2:0] < 3'h5) mf_d = pwdata[2:0];
            if (pwdata[6:4] < 3'h5) ms_d = pwdata[6:4];
        end
        if (wr && paddr == tlr_pkg::OFF_INIT_F) if_d = pwdata;
        if (wr && paddr == tlr_pkg::OFF_INIT_S) is_d = pwdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {st1_q, run_q, prev_q, per_q} <= 4'h0;
            {mf_q, ms_q} <= 6'h00;
            {if_q, is_q} <= 64'h0;
        end else begin
            {st1_q, run_q, prev_q, per_q} <= {st1_d, run_d, prev_d, per_d};
            {mf_q, ms_q} <= {mf_d, ms_d};
            {if_q, is_q} <= {if_d, is_d};
        end
    end

    // ********************
    // Properties
    // ********************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_load;
        st_wr && !per_q ##1 1'b1;
    endsequence

    AST_F_CAPT: assert property (
        sc && cf && data_kind == tlr_pkg::TLR_KIND_FLOAT
        |=> float_value_out == $past(data_in))
        else $error("float capture wrong");
    AST_S_CAPT: assert property (
        sc && cs && data_kind == tlr_pkg::TLR_KIND_LONG
        |=> signed_value_out == $past(data_in))
        else $error("signed capture wrong");
    AST_F_KEEP: assert property (
        sc && !cf |=> $stable(float_value_out))
        else $error("float changed without capture");
    AST_S_KEEP: assert property (
        sc && !cs |=> $stable(signed_value_out))
        else $error("signed changed without capture");
    AST_HOLD: assert property (
        !scan_strobe && !st_wr && !st1_q |=>
        $stable(float_value_out) && $stable(signed_value_out))
        else $error("value moved with no cause");
    AST_INIT: assert property (
        s_load |=> float_value_out == if_q && signed_value_out == is_q)
        else $error("start-up value wrong");
    AST_BOOL: assert property (
        sc && cs && data_kind == tlr_pkg::TLR_KIND_BOOL
        |=> signed_value_out == {31'h0, $past(data_in[0])})
        else $error("boolean store wrong");
    AST_NV_DATA: assert property (
        per_q && sc && cf && data_kind == tlr_pkg::TLR_KIND_FLOAT |=>
        nv_write_data.float_bits == $past(data_in))
        else $error("saved pair differs from capture");
    AST_NV_CAPT: assert property (
        per_q && sc && (cf || cs) |=> nv_write)
        else $error("capture not saved");
    AST_NV_OFF: assert property (
        !per_q |=> !nv_write)
        else $error("save without persistence");
endmodule

bind tlr_top tlr_top_asserts tlr_top_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .scan_strobe(scan_strobe), .data_in(data_in), .data_kind(data_kind),
    .latch_in(latch_in), .latch_connected(latch_connected),
    .nv_write(nv_write), .nv_write_data(nv_write_data),
    .float_value_out(float_value_out), .signed_value_out(signed_value_out)
);

// [tlr_nv_model.sv]
// Behavioural non-volatile store beside the typed latch register
`timescale 1ns/1ps
module tlr_nv_model (
    input  wire logic               pclk,
    input  wire logic               nv_write,
    input  wire tlr_pkg::tlr_pair_s nv_write_data,
    output logic                    nv_saved_valid,
    output tlr_pkg::tlr_pair_s      nv_saved
);
    // No reset: the store outlives a power loss of the controller
    tlr_pkg::tlr_pair_s mem_q;
    logic [63:0]        junk_q;

    initial begin
        nv_saved_valid = 1'b0;
        mem_q = 64'h0;
        junk_q = 64'h5a5a_5a5a_a5a5_a5a5;
    end

    always @(posedge pclk) begin
        junk_q <= ~junk_q;
        if (nv_write) begin
            mem_q <= nv_write_data;
            nv_saved_valid <= 1'b1;
        end
    end

    // An empty store shows a changing pattern, never stale data
    assign nv_saved = nv_saved_valid ? mem_q : junk_q;
endmodule

// [tb.sv]
// Self-checking bench of the typed latch register
`timescale 1ns/1ps
module tb;
    localparam int LIMIT = 5000;
    logic               pclk, presetn, psel, penable, pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rv, ef, es;
    logic               pready, pslverr, re, scan_strobe, latch_in;
    logic               latch_connected, new_project, nv_write;
    logic               nv_saved_valid, l, p;
    logic [31:0]        data_in, float_value_out, signed_value_out;
    tlr_pkg::tlr_kind_e data_kind;
    tlr_pkg::tlr_pair_s nv_saved, nv_write_data;
    int                 miscompares, total_checks, cyc;
    logic [31:0] cd [5] = '{32'h1, 32'h1_fde8, 32'h1_3880,
                            32'h4145_70a4, 32'hc2c5_cccd};
    logic [31:0] xf [5] = '{32'h3f80_0000, 32'h477d_e800, 32'h479c_4000,
                            32'h4145_70a4, 32'hc2c5_cccd};
    logic [31:0] xs [5] = '{32'h1, 32'hfde8, 32'h1_3880, 32'hc,
                            32'hffff_ff9e};

    tlr_top tlr_top_i (.*);
    tlr_nv_model tlr_nv_model_i (.pclk(pclk), .nv_write(nv_write),
        .nv_write_data(nv_write_data), .nv_saved_valid(nv_saved_valid),
        .nv_saved(nv_saved));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ********************
    // Access tasks
    // ********************
    task automatic stop_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic start();
        apb(1'b1, tlr_pkg::OFF_START, 32'h1);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic scan(input logic lv, cv, input tlr_pkg::tlr_kind_e k,
                        input logic [31:0] d);
        @(posedge pclk);
        scan_strobe     <= 1'b1;
        latch_in        <= lv;
        latch_connected <= cv;
        data_kind       <= k;
        data_in         <= d;
        @(posedge pclk);
        scan_strobe <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic outs(input logic [31:0] f, s);
        chk(float_value_out, f);
        chk(signed_value_out, s);
    endtask

    function automatic logic capt(input int m, input logic lv, pv);
        case (m)
            0: capt = lv;
            1: capt = !lv;
            2: capt = lv && !pv;
            3: capt = !lv && pv;
            default: capt = lv != pv;
        endcase
    endfunction

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            stop_test();
        end
    end

    // ********************
    // Scenarios
    // ********************
    initial begin
        {presetn, psel, penable, pwrite, scan_strobe} = 5'h0;
        {latch_in, latch_connected, new_project} = 3'h0;
        {paddr, pwdata, data_in} = 72'h0;
        data_kind = tlr_pkg::TLR_KIND_LONG;
        {miscompares, total_checks, cyc} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tlr_pkg::OFF_CTRL, 32'h0);
        chk(rv, tlr_pkg::RST_CTRL);
        apb(1'b0, tlr_pkg::OFF_INIT_F, 32'h0);
        chk(rv, tlr_pkg::RST_INIT_F);
        scan(1'b1, 1'b1, tlr_pkg::TLR_KIND_LONG, 32'h5);
        outs(32'h0, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, re}, 32'h1);
        apb(1'b1, tlr_pkg::OFF_FVAL, 32'h1234);
        chk({31'h0, re}, 32'h1);
        apb(1'b1, tlr_pkg::OFF_INIT_F, 32'h3f80_0000);
        apb(1'b1, tlr_pkg::OFF_INIT_S, 32'hffff_fff6);
        // Each mode restarts so the previous latch sample is cleared
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, tlr_pkg::OFF_CTRL, {25'h0, m[2:0], 1'b0, m[2:0]});
            start();
            ef = 32'h3f80_0000;
            es = 32'hffff_fff6;
            p  = 1'b0;
            outs(ef, es);
            for (int i = 0; i < 6; i++) begin
                l = 6'b011011 >> i;
                scan(l, 1'(6'b110111 >> i), tlr_pkg::TLR_KIND_LONG,
                     32'h1 << (i + 2));
                l = l & latch_connected;
                if (capt(m, l, p)) begin
                    es = 32'h1 << (i + 2);
                    ef = {1'b0, 8'(129 + i), 23'h0};
                end
                p = l;
                outs(ef, es);
            end
        end
        apb(1'b1, tlr_pkg::OFF_CTRL, 32'h0);
        for (int i = 0; i < 5; i++) begin
            scan(1'b1, 1'b1, tlr_pkg::tlr_kind_e'(i < 4 ? i : 3), cd[i]);
            outs(xf[i], xs[i]);
        end
        apb(1'b1, tlr_pkg::OFF_CTRL, 32'h100);
        scan(1'b1, 1'b1, tlr_pkg::TLR_KIND_FLOAT, 32'h4049_0fdb);
        chk({31'h0, nv_write}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        outs(32'h0, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, tlr_pkg::OFF_CTRL, 32'h100);
        start();
        outs(32'h4049_0fdb, 32'h3);
        apb(1'b0, tlr_pkg::OFF_STAT, 32'h0);
        chk({29'h0, re, rv[1:0]}, 32'h3);
        apb(1'b1, tlr_pkg::OFF_CTRL, 32'h300);
        start();
        outs(32'h4049_0fdb, 32'h3);
        @(posedge pclk) new_project <= 1'b1;
        start();
        outs(32'h0, 32'h0);
        stop_test();
    end
endmodule
